// ==== verilog/amf_pkg.sv ====
// How it works
// - start byte fb, then remaining length
// - third byte is packet type 27
// - short status: length 02, a0 or a1
// - invalid argument e1, read-only write e4
// - reset cause: brownout ec, watchdog ed
// - crystal or radio fault sends ee
// - join: length 06, a3, id, parent mac
// - exit: length 03, a4, parent id
// - heartbeat: length 0c, a8, own, parent mac
// - parent id, router id or ff
// - beacon power averaged, weight one sixteenth
// - parent received power, 7f when invalid
package amf_pkg;

   // ******************************
   // message framing constants
   // ******************************
   localparam logic [7:0] START_BYTE = 8'hfb;
   localparam logic [7:0] PKT_TYPE = 8'h27;
   localparam logic [7:0] LEN_SHORT = 8'h02;
   localparam logic [7:0] LEN_JOIN = 8'h06;
   localparam logic [7:0] LEN_EXIT = 8'h03;
   localparam logic [7:0] LEN_BEAT = 8'h0c;
   localparam logic [7:0] HDR_BYTES = 8'h02;
   localparam logic [7:0] NO_NET_ID = 8'hff;
   localparam logic signed [7:0] PWR_INVALID = 8'sh7f;
   localparam logic signed [7:0] PWR_MAX_VALID = 8'sh7e;
   localparam int FILT_SHIFT = 4;
   localparam int FILT_FRAC = 4;

   // ******************************
   // status codes
   // ******************************
   localparam logic [7:0] ST_STARTUP = 8'ha0;
   localparam logic [7:0] ST_FAST_BCN = 8'ha1;
   localparam logic [7:0] ST_JOINED = 8'ha3;
   localparam logic [7:0] ST_EXITED = 8'ha4;
   localparam logic [7:0] ST_BEAT = 8'ha8;
   localparam logic [7:0] ST_BAD_ARG = 8'he1;
   localparam logic [7:0] ST_READ_ONLY = 8'he4;
   localparam logic [7:0] ST_BROWNOUT = 8'hec;
   localparam logic [7:0] ST_WATCHDOG = 8'hed;
   localparam logic [7:0] ST_HW_ERR = 8'hee;

   // ******************************
   // types
   // ******************************
   typedef enum logic [3:0] {
      AMF_EV_STARTUP,
      AMF_EV_FAST_BCN,
      AMF_EV_BAD_ARG,
      AMF_EV_READ_ONLY,
      AMF_EV_BROWNOUT,
      AMF_EV_WATCHDOG,
      AMF_EV_HW_ERR,
      AMF_EV_JOIN,
      AMF_EV_EXIT,
      AMF_EV_BEAT
   } amf_event_t;

   typedef struct packed {
      logic [23:0] own_mac;
      logic [23:0] parent_mac;
      logic [7:0] parent_id;
      logic [7:0] base_id;
      logic is_router;
      logic signed [7:0] parent_rx_pwr;
   } amf_net_info_t;

   typedef struct packed {
      logic valid;
      logic [7:0] data;
      logic last;
   } amf_byte_t;

endpackage

// ==== verilog/amf_pwr_filter.sv ====
`timescale 1ns/1ps
// exponential average of beacon power, weight 1/16
module amf_pwr_filter (
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   input wire logic i_sample_valid,
   input wire logic signed [7:0] i_sample,
   output logic signed [7:0] o_avg
);

   // ******************************
   // filter state
   // ******************************
   logic signed [15:0] acc;
   logic have_data;
   logic signed [15:0] next_acc;
   logic next_have_data;
   logic signed [15:0] sample_q;
   logic signed [7:0] next_avg;

   always_comb begin
      sample_q = 16'(i_sample) <<< amf_pkg::FILT_FRAC;
      next_acc = acc;
      next_have_data = have_data;
      if (i_sample_valid && i_sample != amf_pkg::PWR_INVALID) begin
         next_have_data = 1'b1;
         if (!have_data) begin
            next_acc = sample_q;
         end else begin
            next_acc = acc + ((sample_q - acc) >>> amf_pkg::FILT_SHIFT);
         end
      end
      // clamp so a valid average never reads as the invalid marker
      next_avg = 8'(acc >>> amf_pkg::FILT_FRAC);
      if (!have_data) begin
         next_avg = amf_pkg::PWR_INVALID;
      end else if (next_avg == amf_pkg::PWR_INVALID) begin
         next_avg = amf_pkg::PWR_MAX_VALID;
      end
   end

   // register state and output
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         acc <= 16'sh0000;
         have_data <= 1'b0;
         o_avg <= amf_pkg::PWR_INVALID;
      end else begin
         acc <= next_acc;
         have_data <= next_have_data;
         o_avg <= next_avg;
      end
   end

endmodule

// ==== verilog/amf_msg_rom.sv ====
`timescale 1ns/1ps
// selects header and body byte for a message at a byte index
module amf_msg_rom (
   input wire amf_pkg::amf_event_t i_event,
   input wire logic [7:0] i_index,
   input wire amf_pkg::amf_net_info_t i_info,
   input wire logic signed [7:0] i_beacon_pwr,
   output logic [7:0] o_byte,
   output logic [7:0] o_len
);

   // ******************************
   // byte lookup
   // ******************************
   function automatic logic [7:0] status_of(amf_pkg::amf_event_t ev);
      unique case (ev)
         amf_pkg::AMF_EV_STARTUP: status_of = amf_pkg::ST_STARTUP;
         amf_pkg::AMF_EV_FAST_BCN: status_of = amf_pkg::ST_FAST_BCN;
         amf_pkg::AMF_EV_BAD_ARG: status_of = amf_pkg::ST_BAD_ARG;
         amf_pkg::AMF_EV_READ_ONLY: status_of = amf_pkg::ST_READ_ONLY;
         amf_pkg::AMF_EV_BROWNOUT: status_of = amf_pkg::ST_BROWNOUT;
         amf_pkg::AMF_EV_WATCHDOG: status_of = amf_pkg::ST_WATCHDOG;
         amf_pkg::AMF_EV_HW_ERR: status_of = amf_pkg::ST_HW_ERR;
         amf_pkg::AMF_EV_JOIN: status_of = amf_pkg::ST_JOINED;
         amf_pkg::AMF_EV_EXIT: status_of = amf_pkg::ST_EXITED;
         amf_pkg::AMF_EV_BEAT: status_of = amf_pkg::ST_BEAT;
         default: status_of = amf_pkg::ST_HW_ERR;
      endcase
   endfunction

   always_comb begin
      o_len = amf_pkg::LEN_SHORT;
      if (i_event == amf_pkg::AMF_EV_JOIN) begin
         o_len = amf_pkg::LEN_JOIN;
      end else if (i_event == amf_pkg::AMF_EV_EXIT) begin
         o_len = amf_pkg::LEN_EXIT;
      end else if (i_event == amf_pkg::AMF_EV_BEAT) begin
         o_len = amf_pkg::LEN_BEAT;
      end
      o_byte = 8'h00;
      unique case (i_index)
         8'h00: o_byte = amf_pkg::START_BYTE;
         8'h01: o_byte = o_len;
         8'h02: o_byte = amf_pkg::PKT_TYPE;
         8'h03: o_byte = status_of(i_event);
         default: begin
            if (i_event == amf_pkg::AMF_EV_JOIN) begin
               unique case (i_index)
                  8'h04: o_byte = i_info.parent_id;
                  8'h05: o_byte = i_info.parent_mac[7:0];
                  8'h06: o_byte = i_info.parent_mac[15:8];
                  8'h07: o_byte = i_info.parent_mac[23:16];
                  default: o_byte = 8'h00;
               endcase
            end else if (i_event == amf_pkg::AMF_EV_EXIT) begin
               o_byte = i_info.parent_id;
            end else begin
               unique case (i_index)
                  8'h04: o_byte = i_info.own_mac[7:0];
                  8'h05: o_byte = i_info.own_mac[15:8];
                  8'h06: o_byte = i_info.own_mac[23:16];
                  8'h07: o_byte = i_info.parent_mac[7:0];
                  8'h08: o_byte = i_info.parent_mac[15:8];
                  8'h09: o_byte = i_info.parent_mac[23:16];
                  8'h0a: o_byte = i_info.parent_id;
                  8'h0b: o_byte = i_info.is_router ? i_info.base_id
                                                   : amf_pkg::NO_NET_ID;
                  8'h0c: o_byte = i_beacon_pwr;
                  8'h0d: o_byte = i_info.parent_rx_pwr;
                  default: o_byte = 8'h00;
               endcase
            end
         end
      endcase
   end

endmodule

// ==== verilog/amf_framer.sv ====
`timescale 1ns/1ps
// serialises one announce message per accepted event
module amf_framer (
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   input wire logic i_ev_valid,
   output logic o_ev_ready,
   input wire amf_pkg::amf_event_t i_ev_kind,
   input wire amf_pkg::amf_net_info_t i_info,
   input wire logic i_bcn_valid,
   input wire logic signed [7:0] i_bcn_pwr,
   output amf_pkg::amf_byte_t o_tx,
   input wire logic i_tx_ready
);

   // ******************************
   // state
   // ******************************
   typedef enum logic {
      AMF_IDLE,
      AMF_SEND
   } amf_state_t;

   amf_state_t state;
   amf_state_t next_state;
   amf_pkg::amf_event_t ev;
   amf_pkg::amf_event_t next_ev;
   amf_pkg::amf_net_info_t info;
   amf_pkg::amf_net_info_t next_info;
   logic [7:0] idx;
   logic [7:0] next_idx;
   amf_pkg::amf_byte_t next_tx;
   logic [7:0] rom_byte;
   logic [7:0] rom_len;
   logic [7:0] rom_next_byte;
   logic [7:0] last_idx;
   logic signed [7:0] bcn_avg;

   // ******************************
   // submodules
   // ******************************
   amf_pwr_filter u_filter (
      .i_ref_clk(i_ref_clk),
      .i_sys_rst(i_sys_rst),
      .i_sample_valid(i_bcn_valid),
      .i_sample(i_bcn_pwr),
      .o_avg(bcn_avg)
   );

   // lookup of the next byte to present
   amf_msg_rom u_rom (
      .i_event(next_ev),
      .i_index(next_idx),
      .i_info(next_info),
      .i_beacon_pwr(bcn_avg),
      .o_byte(rom_next_byte),
      .o_len(rom_len)
   );

   assign rom_byte = rom_next_byte;
   assign o_ev_ready = (state == AMF_IDLE);

   // next state, event, info and index
   always_comb begin
      next_state = state;
      next_ev = ev;
      next_info = info;
      next_idx = idx;
      unique case (state)
         AMF_IDLE: begin
            if (i_ev_valid) begin
               next_state = AMF_SEND;
               next_ev = i_ev_kind;
               next_info = i_info;
               next_idx = 8'h00;
            end
         end
         AMF_SEND: begin
            if (i_tx_ready) begin
               if (o_tx.last) begin
                  next_state = AMF_IDLE;
               end else begin
                  next_idx = 8'(idx + 8'h01);
               end
            end
         end
      endcase
   end

   // next output byte, looked up at the next index
   // kept apart from the state logic so the lookup forms no loop
   always_comb begin
      next_tx = o_tx;
      last_idx = 8'(rom_len + amf_pkg::HDR_BYTES - 8'h01);
      if (next_state == AMF_SEND) begin
         next_tx.valid = 1'b1;
         next_tx.data = rom_byte;
         next_tx.last = (next_idx == last_idx);
      end else begin
         next_tx.valid = 1'b0;
         next_tx.last = 1'b0;
      end
   end

   // register all state
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         state <= AMF_IDLE;
         ev <= amf_pkg::AMF_EV_STARTUP;
         info <= '0;
         idx <= 8'h00;
         o_tx <= '0;
      end else begin
         state <= next_state;
         ev <= next_ev;
         info <= next_info;
         idx <= next_idx;
         o_tx <= next_tx;
      end
   end

endmodule

// ==== dv/amf_framer_props.sv ====
`timescale 1ns/1ps
// *****
// checks on the byte stream of the framer
// *****
module amf_framer_props (
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   input wire logic i_ev_valid,
   input wire logic o_ev_ready,
   input wire amf_pkg::amf_event_t i_ev_kind,
   input wire amf_pkg::amf_net_info_t i_info,
   input wire logic i_bcn_valid,
   input wire logic signed [7:0] i_bcn_pwr,
   input wire amf_pkg::amf_byte_t o_tx,
   input wire logic i_tx_ready
);
   default clocking @(posedge i_ref_clk);
   endclocking
   default disable iff (i_sys_rst);
   logic [7:0] idx;
   logic [7:0] len;
   logic [7:0] next_idx;
   logic [7:0] next_len;
   wire logic tk = o_tx.valid && i_tx_ready;
   // byte position and length of the message on the wire
   always_comb begin
      next_idx = idx;
      next_len = len;
      if (tk) begin
         next_idx = o_tx.last ? 8'h00 : idx + 8'h01;
      end
      if (tk && idx == 8'h01) begin
         next_len = o_tx.data;
      end
   end
   // registers the tracker
   always_ff @(posedge i_ref_clk) begin
      idx <= i_sys_rst ? 8'h00 : next_idx;
      len <= next_len;
   end
   chk_start_byte: assert property (
      $rose(o_tx.valid) |-> o_tx.data == 8'hfb)
      else $error("message does not open with start byte");
   chk_accept_answer: assert property (
      i_ev_valid && o_ev_ready |=>
      o_tx.valid && o_tx.data == 8'hfb && !o_ev_ready)
      else $error("accepted event not answered next cycle");
   chk_byte_hold: assert property (
      o_tx.valid && !i_tx_ready |=> $stable(o_tx))
      else $error("byte changed while host stalled");
   chk_type_byte: assert property (
      o_tx.valid && idx == 8'h02 |-> o_tx.data == 8'h27)
      else $error("third byte is not the packet type");
   chk_len_count: assert property (
      o_tx.valid && o_tx.last |-> idx == len + 8'h01)
      else $error("byte count disagrees with length byte");
   chk_ready_gap: assert property (
      tk && o_tx.last |=> !o_tx.valid && o_ev_ready)
      else $error("no idle gap after last byte");
   chk_busy_refuse: assert property (
      o_tx.valid |-> !o_ev_ready)
      else $error("ready while a message is sent");
   chk_status_len: assert property (
      o_tx.valid && idx == 8'h03 |->
      (o_tx.data inside {8'ha0, 8'ha1, 8'he1, 8'he4, 8'hec, 8'hed,
      8'hee} && len == 8'h02) || (o_tx.data == 8'ha3 && len == 8'h06)
      || (o_tx.data == 8'ha4 && len == 8'h03)
      || (o_tx.data == 8'ha8 && len == 8'h0c))
      else $error("status byte and length do not match");
endmodule
bind amf_framer amf_framer_props u_props (
   .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
   .i_ev_valid(i_ev_valid), .o_ev_ready(o_ev_ready),
   .i_ev_kind(i_ev_kind), .i_info(i_info), .i_bcn_valid(i_bcn_valid),
   .i_bcn_pwr(i_bcn_pwr), .o_tx(o_tx), .i_tx_ready(i_tx_ready)
);

// ==== dv/amf_host.sv ====
`timescale 1ns/1ps
// host that parses the byte stream, may stall every other cycle
module amf_host (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_slow,
   input wire amf_pkg::amf_byte_t i_rx,
   output logic o_ready,
   output logic [7:0] o_msgs,
   output logic [7:0] o_n,
   output logic [15:0][7:0] o_msg
);
   logic [7:0] cnt;
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_ready <= 1'b0;
         cnt <= 8'h00;
         o_msgs <= 8'h00;
      end else begin
         o_ready <= i_slow ? ~o_ready : 1'b1;
         if (i_rx.valid && o_ready &&
            (cnt != 8'h00 || i_rx.data == 8'hfb)) begin
            o_msg[cnt[3:0]] <= i_rx.data;
            cnt <= cnt + 8'h01;
            if (cnt > 8'h01 && cnt == o_msg[1] + 8'h01) begin
               cnt <= 8'h00;
               o_n <= cnt + 8'h01;
               o_msgs <= o_msgs + 8'h01;
            end
         end
      end
   end
endmodule

// ==== dv/tb_announce_message_framer.sv ====
`timescale 1ns/1ps
module tb_announce_message_framer;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ev_valid = 1'b0;
   logic rdy;
   amf_pkg::amf_event_t kind = amf_pkg::AMF_EV_STARTUP;
   amf_pkg::amf_net_info_t info =
      {24'h332211, 24'h665544, 8'h07, 8'h09, 1'b0, 8'hb0};
   logic bv = 1'b0;
   logic signed [7:0] bp = 8'sh00;
   logic slow = 1'b0;
   amf_pkg::amf_byte_t tx;
   logic tr;
   logic [7:0] msgs;
   logic [7:0] n;
   logic [15:0][7:0] msg;
   int miscompares = 0;
   int n_compared = 0;
   always #4 clk = ~clk;
   amf_framer dut (.i_ref_clk(clk), .i_sys_rst(rst), .i_ev_valid(ev_valid),
      .o_ev_ready(rdy), .i_ev_kind(kind), .i_info(info), .i_bcn_valid(bv),
      .i_bcn_pwr(bp), .o_tx(tx), .i_tx_ready(tr));
   amf_host host (.i_clk(clk), .i_rst(rst), .i_slow(slow), .i_rx(tx),
      .o_ready(tr), .o_msgs(msgs), .o_n(n), .o_msg(msg));
   task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic give_verdict;
      if (miscompares == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // sends one event and compares the parsed message
   task automatic run(amf_pkg::amf_event_t k, logic [7:0] exp[$]);
      logic [7:0] m;
      m = msgs;
      while (rdy !== 1'b1) @(negedge clk);
      @(posedge clk);
      ev_valid <= 1'b1;
      kind <= k;
      @(posedge clk);
      ev_valid <= 1'b0;
      for (int i = 0; i < 99 && msgs === m; i++) @(negedge clk);
      check("messages", msgs, 8'(m + 8'h01));
      check("length", n, 8'(exp.size()));
      foreach (exp[i]) check("byte", msg[i], exp[i]);
   endtask
   // every short status code
   task automatic t_short;
      logic [7:0] c[7] = '{8'ha0, 8'ha1, 8'he1, 8'he4, 8'hec, 8'hed, 8'hee};
      for (int k = 0; k < 7; k++) begin
         run(amf_pkg::amf_event_t'(k), '{8'hfb, 8'h02, 8'h27, c[k]});
      end
   endtask
   // join and exit notices
   task automatic t_net;
      run(amf_pkg::AMF_EV_JOIN, '{8'hfb, 8'h06, 8'h27, 8'ha3, 8'h07,
         8'h44, 8'h55, 8'h66});
      run(amf_pkg::AMF_EV_EXIT, '{8'hfb, 8'h03, 8'h27, 8'ha4, 8'h07});
   endtask
   // heartbeat before and after beacon samples, slow host on the second
   task automatic t_beat;
      run(amf_pkg::AMF_EV_BEAT, '{8'hfb, 8'h0c, 8'h27, 8'ha8, 8'h11, 8'h22,
         8'h33, 8'h44, 8'h55, 8'h66, 8'h07, 8'hff, 8'h7f, 8'hb0});
      @(posedge clk);
      bv <= 1'b1;
      bp <= -8'sd60;
      @(posedge clk);
      bp <= -8'sd44;
      @(posedge clk);
      bp <= 8'sh7f;
      @(posedge clk);
      bv <= 1'b0;
      info.is_router <= 1'b1;
      slow <= 1'b1;
      run(amf_pkg::AMF_EV_BEAT, '{8'hfb, 8'h0c, 8'h27, 8'ha8, 8'h11, 8'h22,
         8'h33, 8'h44, 8'h55, 8'h66, 8'h07, 8'h09, 8'hc5, 8'hb0});
   endtask
   // main sequence
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      t_short;
      t_net;
      t_beat;
      give_verdict;
   end
   // watchdog
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      give_verdict;
   end
endmodule
